//--- core/dcwd_top.sv
// drive control word decoder: register writes into state machine commands
`timescale 1ns/1ps
`default_nettype none
module dcwd_top
	import dcwd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic wr_valid_i,
	input wire logic [DCWD_ADDR_W-1:0] wr_addr_i,
	input wire logic [DCWD_DATA_W-1:0] wr_data_i,
	input wire logic wr_size32_i,
	input wire logic channel_modbus_i,
	input wire logic channel_blocked_i,
	input wire logic [3:0] drive_state_i,
	output logic resp_ack_o,
	output logic resp_err_o,
	output logic power_off_request_o,
	output logic power_on_request_o,
	output logic emergency_decel_request_o,
	output logic error_clear_request_o,
	output logic pause_request_o,
	output logic pause_clear_request_o,
	output logic pause_resume_request_o,
	output logic mode_start_o,
	output logic [DCWD_MODE_SEL_W-1:0] mode_select_o,
	output logic [DCWD_ACTION_W-1:0] mode_action_o,
	output logic [15:0] ref16_o,
	output logic [31:0] ref32_o
);
	// whether the drive state can execute a command
	function automatic logic cmd_allowed(input dcwd_cmd_e cmd, input logic [3:0] st);
		logic ok;
		ok = 1'b1;
		case (cmd)
			DCWD_CMD_ON: ok = (st == DCWD_ST_READY) || (st == DCWD_ST_SWITCHED_ON);
			DCWD_CMD_DECEL: ok = (st == DCWD_ST_SWITCHED_ON) || (st == DCWD_ST_RUNNING);
			DCWD_CMD_ERRCLR: ok = (st == DCWD_ST_FAULT);
			DCWD_CMD_PAUSE: ok = (st == DCWD_ST_RUNNING);
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction

	logic [DCWD_CMD_W-1:0] cmd_word;
	logic [7:0] mode_byte;
	logic addr_ok;
	logic chan_ok;
	logic acc_cmd;
	logic acc_ref;
	logic [DCWD_CMD_W-1:0] rise;
	logic [DCWD_CMD_W-1:0] tog;
	dcwd_resp_e resp;
	dcwd_resp_e next_resp;

	// fields of the incoming word
	assign cmd_word = wr_data_i[DCWD_CMD_LSB +: DCWD_CMD_W];
	assign mode_byte = cmd_word[DCWD_MODE_LSB +: 8];
	assign addr_ok = (wr_addr_i == DCWD_ADDR_CMD) || (wr_addr_i == DCWD_ADDR_REF);
	assign chan_ok = channel_modbus_i && !channel_blocked_i;
	// a write is taken only if wide, mapped and permitted
	assign acc_cmd = wr_valid_i && wr_size32_i && chan_ok && (wr_addr_i == DCWD_ADDR_CMD);
	assign acc_ref = wr_valid_i && wr_size32_i && chan_ok && (wr_addr_i == DCWD_ADDR_REF);

	// previous command held between writes
	dcwd_edge u_edge (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.load_i(acc_cmd),
		.data_i(cmd_word),
		.rise_o(rise),
		.toggle_o(tog)
	);

	// answer of the access
	always_comb begin
		next_resp = DCWD_RESP_NONE;
		if (wr_valid_i) begin
			if (!wr_size32_i || !addr_ok || !chan_ok) begin
				next_resp = DCWD_RESP_ERR;
			end else begin
				next_resp = DCWD_RESP_ACK;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			resp <= DCWD_RESP_NONE;
		end else begin
			resp <= next_resp;
		end
	end

	assign resp_ack_o = (resp == DCWD_RESP_ACK);
	assign resp_err_o = (resp == DCWD_RESP_ERR);

	// state machine command pulses
	logic next_off;
	logic next_on;
	logic next_decel;
	logic next_errclr;
	logic next_pause;
	logic next_pclr;
	logic next_pres;
	logic drv_zero;

	assign drv_zero = (cmd_word[DCWD_DRV_LSB +: 8] == 8'h00);

	always_comb begin
		next_off = 1'b0;
		next_on = 1'b0;
		next_decel = 1'b0;
		next_errclr = 1'b0;
		next_pause = 1'b0;
		next_pclr = 1'b0;
		next_pres = 1'b0;
		if (acc_cmd) begin
			// disable on its edge or on an all-zero drive word
			next_off = rise[DCWD_BIT_OFF] || drv_zero;
			// enable loses against a set disable bit
			next_on = rise[DCWD_BIT_ON] && !cmd_word[DCWD_BIT_OFF]
				&& cmd_allowed(DCWD_CMD_ON, drive_state_i);
			next_decel = rise[DCWD_BIT_DECEL]
				&& cmd_allowed(DCWD_CMD_DECEL, drive_state_i);
			// fault reset loses against a set quick stop bit
			next_errclr = rise[DCWD_BIT_ERRCLR] && !cmd_word[DCWD_BIT_DECEL]
				&& cmd_allowed(DCWD_CMD_ERRCLR, drive_state_i);
			next_pause = rise[DCWD_BIT_PAUSE]
				&& cmd_allowed(DCWD_CMD_PAUSE, drive_state_i);
			// halt bit suppresses clear and resume
			next_pclr = rise[DCWD_BIT_PCLR] && !cmd_word[DCWD_BIT_PAUSE]
				&& cmd_allowed(DCWD_CMD_PAUSE, drive_state_i);
			next_pres = rise[DCWD_BIT_PRES] && !cmd_word[DCWD_BIT_PAUSE]
				&& cmd_allowed(DCWD_CMD_PAUSE, drive_state_i);
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			power_off_request_o <= 1'b0;
			power_on_request_o <= 1'b0;
			emergency_decel_request_o <= 1'b0;
			error_clear_request_o <= 1'b0;
			pause_request_o <= 1'b0;
			pause_clear_request_o <= 1'b0;
			pause_resume_request_o <= 1'b0;
		end else begin
			power_off_request_o <= next_off;
			power_on_request_o <= next_on;
			emergency_decel_request_o <= next_decel;
			error_clear_request_o <= next_errclr;
			pause_request_o <= next_pause;
			pause_clear_request_o <= next_pclr;
			pause_resume_request_o <= next_pres;
		end
	end

	// operating mode data and references
	logic next_mode_start;
	logic [DCWD_MODE_SEL_W-1:0] next_mode_select;
	logic [DCWD_ACTION_W-1:0] next_mode_action;
	logic [15:0] next_ref16;
	logic [31:0] next_ref32;
	logic [31:0] ref32_stage;
	logic [31:0] next_ref32_stage;

	always_comb begin
		next_mode_start = 1'b0;
		next_mode_select = mode_select_o;
		next_mode_action = mode_action_o;
		next_ref16 = ref16_o;
		next_ref32 = ref32_o;
		next_ref32_stage = ref32_stage;
		if (acc_ref) begin
			next_ref32_stage = wr_data_i; // staged until the toggle
		end
		// zero mode byte skips the data, toggle releases it
		if (acc_cmd && (mode_byte != 8'h00) && tog[DCWD_BIT_TOGGLE]) begin
			next_mode_start = 1'b1;
			next_mode_select = mode_byte[DCWD_MODE_SEL_LSB +: DCWD_MODE_SEL_W];
			next_mode_action = mode_byte[DCWD_ACTION_LSB +: DCWD_ACTION_W];
			next_ref16 = wr_data_i[DCWD_REF16_LSB +: 16];
			next_ref32 = ref32_stage;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_start_o <= 1'b0;
			mode_select_o <= '0;
			mode_action_o <= '0;
			ref16_o <= '0;
			ref32_o <= DCWD_WORD_RESET;
			ref32_stage <= DCWD_WORD_RESET;
		end else begin
			mode_start_o <= next_mode_start;
			mode_select_o <= next_mode_select;
			mode_action_o <= next_mode_action;
			ref16_o <= next_ref16;
			ref32_o <= next_ref32;
			ref32_stage <= next_ref32_stage;
		end
	end

	// narrow access refused with no command
	a_narrow_refused: assert property (@(posedge mclk_i) disable iff (reset_i)
		wr_valid_i && !wr_size32_i |=> resp_err_o && !power_off_request_o && !mode_start_o)
		else $error("16-bit access not refused");

	// blocked channel refused
	a_blocked_refused: assert property (@(posedge mclk_i) disable iff (reset_i)
		wr_valid_i && wr_size32_i && !chan_ok |=> resp_err_o && !power_off_request_o)
		else $error("write on unavailable channel taken");

	// mapped write acknowledged
	a_mapped_ack: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd || acc_ref |=> resp_ack_o && !resp_err_o)
		else $error("mapped write not acknowledged");

	// decel only after its own edge
	a_decel_edge: assert property (@(posedge mclk_i) disable iff (reset_i)
		!(acc_cmd && rise[DCWD_BIT_DECEL]) |=> !emergency_decel_request_o)
		else $error("quick stop without rising edge");

	// enable never beside disable
	a_off_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && cmd_word[DCWD_BIT_OFF] |=> !power_on_request_o)
		else $error("enable obeyed with disable set");

	// fault reset never beside quick stop bit
	a_decel_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && cmd_word[DCWD_BIT_DECEL] |=> !error_clear_request_o)
		else $error("fault reset obeyed with quick stop set");

	// halt suppresses clear and resume
	a_pause_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && cmd_word[DCWD_BIT_PAUSE] |=> !pause_clear_request_o && !pause_resume_request_o)
		else $error("halt precedence broken");

	// all-zero drive word disables
	a_zero_off: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && drv_zero |=> power_off_request_o)
		else $error("zero drive word did not disable");

	// quick stop dropped in ready state
	a_ready_drop: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && drive_state_i == DCWD_ST_READY |=> !emergency_decel_request_o)
		else $error("quick stop executed in ready state");

	// toggle releases the mode data
	a_toggle_start: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && mode_byte != 8'h00 && tog[DCWD_BIT_TOGGLE]
		|=> mode_start_o && mode_select_o == $past(mode_byte[3:0]))
		else $error("mode toggle not taken");

	// zero mode byte ignored
	a_mode_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && mode_byte == 8'h00 |=> !mode_start_o && $stable(ref16_o))
		else $error("zero mode byte processed");

	// unmapped address refused
	a_unmapped_refused: assert property (@(posedge mclk_i) disable iff (reset_i)
		wr_valid_i && wr_size32_i && chan_ok && !addr_ok |=> resp_err_o && !resp_ack_o)
		else $error("unmapped write not refused");

	// no answer without a write
	a_resp_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
		!wr_valid_i |=> !resp_ack_o && !resp_err_o)
		else $error("answer without a write");

	// no command pulse without an accepted write
	a_idle_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
		!acc_cmd |=> !power_off_request_o && !power_on_request_o
			&& !emergency_decel_request_o && !error_clear_request_o && !pause_request_o
			&& !pause_clear_request_o && !pause_resume_request_o && !mode_start_o)
		else $error("command pulse without a write");

	// enable edge obeyed in ready or switched on
	a_on_fires: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && rise[DCWD_BIT_ON] && !cmd_word[DCWD_BIT_OFF]
			&& (drive_state_i == DCWD_ST_READY || drive_state_i == DCWD_ST_SWITCHED_ON)
		|=> power_on_request_o)
		else $error("enable edge not obeyed");

	// quick stop edge obeyed while running
	a_decel_fires: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && rise[DCWD_BIT_DECEL] && drive_state_i == DCWD_ST_RUNNING
		|=> emergency_decel_request_o)
		else $error("quick stop edge not obeyed");

	// fault reset edge obeyed in fault state
	a_errclr_fires: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && rise[DCWD_BIT_ERRCLR] && !cmd_word[DCWD_BIT_DECEL]
			&& drive_state_i == DCWD_ST_FAULT |=> error_clear_request_o)
		else $error("fault reset edge not obeyed");

	// fault reset dropped outside fault state
	a_errclr_dropped: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && drive_state_i != DCWD_ST_FAULT |=> !error_clear_request_o)
		else $error("fault reset executed outside fault state");

	// halt edge obeyed while running
	a_pause_fires: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && rise[DCWD_BIT_PAUSE] && drive_state_i == DCWD_ST_RUNNING
		|=> pause_request_o)
		else $error("halt edge not obeyed");

	// staged reference released with the toggle
	a_ref_staged: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && mode_byte != 8'h00 && tog[DCWD_BIT_TOGGLE]
		|=> ref32_o == $past(ref32_stage))
		else $error("staged reference not released");

	// no toggle, no new mode data
	a_no_toggle: assert property (@(posedge mclk_i) disable iff (reset_i)
		acc_cmd && !tog[DCWD_BIT_TOGGLE] |=> !mode_start_o && $stable(mode_select_o))
		else $error("mode data taken without toggle");
endmodule
`default_nettype wire

//--- core/dcwd_pkg.sv
// constants and types of the drive control word decoder
// How it works
// - only 32-bit register accesses; 16-bit rejected
// - two adjacent 32-bit control registers
// - writes need free Modbus access channel
// - decode writes at 6922 and 6924
// - commands fire on rising edges, immediately
// - bit 10 rising starts quick stop
// - bit 11 rising starts fault reset
// - disable bit 8 beats enable bit 9
// - quick stop beats fault reset
// - halt bit 13 beats bits 14, 15
// - all-zero drive word disables power stage
// - silently drop requests illegal in state
// - mode data taken only on toggle bit
// - all-zero mode byte skips reference data
package dcwd_pkg;
	// register addresses, as Modbus register numbers
	localparam logic [15:0] DCWD_ADDR_CMD = 16'h1b0a;
	localparam logic [15:0] DCWD_ADDR_REF = 16'h1b0c;
	localparam int DCWD_ADDR_W = 16;
	localparam int DCWD_DATA_W = 32;
	localparam int DCWD_CMD_W = 16;
	// reset value of the held previous command
	localparam logic [15:0] DCWD_PREV_RESET = 16'h0000;
	localparam logic [31:0] DCWD_WORD_RESET = 32'h0000_0000;
	// fields of the command register
	localparam int DCWD_CMD_LSB = 0;
	localparam int DCWD_REF16_LSB = 16;
	localparam int DCWD_DRV_LSB = 8;
	localparam int DCWD_MODE_LSB = 0;
	localparam int DCWD_MODE_SEL_LSB = 0;
	localparam int DCWD_MODE_SEL_W = 4;
	localparam int DCWD_ACTION_LSB = 4;
	localparam int DCWD_ACTION_W = 3;
	// drive control bits inside drive_mode_command
	localparam int DCWD_BIT_OFF = 8;
	localparam int DCWD_BIT_ON = 9;
	localparam int DCWD_BIT_DECEL = 10;
	localparam int DCWD_BIT_ERRCLR = 11;
	localparam int DCWD_BIT_PAUSE = 13;
	localparam int DCWD_BIT_PCLR = 14;
	localparam int DCWD_BIT_PRES = 15;
	// mode toggle bit inside the mode selector byte
	localparam int DCWD_BIT_TOGGLE = 7;
	// drive state codes seen from the state machine
	localparam logic [3:0] DCWD_ST_READY = 4'h4;
	localparam logic [3:0] DCWD_ST_SWITCHED_ON = 4'h5;
	localparam logic [3:0] DCWD_ST_RUNNING = 4'h6;
	localparam logic [3:0] DCWD_ST_FAULT = 4'h9;
	// answer of one register access
	typedef enum logic [1:0] {
		DCWD_RESP_NONE = 2'b00,
		DCWD_RESP_ACK = 2'b01,
		DCWD_RESP_ERR = 2'b10
	} dcwd_resp_e;
	// command kinds for the state check
	typedef enum logic [2:0] {
		DCWD_CMD_ON = 3'b000,
		DCWD_CMD_DECEL = 3'b001,
		DCWD_CMD_ERRCLR = 3'b010,
		DCWD_CMD_PAUSE = 3'b011,
		DCWD_CMD_OTHER = 3'b100
	} dcwd_cmd_e;
endpackage

//--- core/dcwd_edge.sv
// held previous command word with rising-edge and toggle detection
`timescale 1ns/1ps
`default_nettype none
module dcwd_edge
	import dcwd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic load_i,
	input wire logic [DCWD_CMD_W-1:0] data_i,
	output logic [DCWD_CMD_W-1:0] rise_o,
	output logic [DCWD_CMD_W-1:0] toggle_o
);
	logic [DCWD_CMD_W-1:0] prev;
	logic [DCWD_CMD_W-1:0] next_prev;

	// edges against the last accepted write
	assign rise_o = data_i & ~prev;
	assign toggle_o = data_i ^ prev;

	// previous value moves only on an accepted write
	always_comb begin
		next_prev = prev;
		if (load_i) begin
			next_prev = data_i;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			prev <= DCWD_PREV_RESET;
		end else begin
			prev <= next_prev;
		end
	end

	// previous value held across idle cycles
	a_prev_held: assert property (@(posedge mclk_i) disable iff (reset_i)
		!load_i |=> prev == $past(prev))
		else $error("previous command changed without a write");
endmodule
`default_nettype wire

//--- dv/dcwd_ctrl_model.sv
// fieldbus controller model issuing I/O scanning register writes
`timescale 1ns/1ps
`default_nettype none
module dcwd_ctrl_model
	import dcwd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resp_ack_i,
	input wire logic resp_err_i,
	output logic wr_valid_o,
	output logic [DCWD_ADDR_W-1:0] wr_addr_o,
	output logic [DCWD_DATA_W-1:0] wr_data_o,
	output logic wr_size32_o
);
	// idle bus values at time zero
	initial begin
		wr_valid_o = 1'b0;
		wr_addr_o = 16'h0000;
		wr_data_o = 32'h0000_0000;
		wr_size32_o = 1'b0;
	end
	// one write held over the taking edge, answer read in the cycle after
	task automatic write(input logic [15:0] a, input logic [31:0] d, input logic sz,
		output logic [1:0] resp);
		@(posedge mclk_i);
		#1;
		wr_valid_o = 1'b1;
		wr_addr_o = a;
		wr_data_o = d; // reference or command word, as the caller gives it
		wr_size32_o = sz; // 32-bit unless a refusal is wanted
		@(posedge mclk_i);
		#1;
		resp = {resp_err_i, resp_ack_i};
		// released lines show inverted leftovers, not the old value
		wr_valid_o = 1'b0;
		wr_addr_o = ~a;
		wr_data_o = ~d;
		wr_size32_o = ~sz;
	endtask
endmodule
`default_nettype wire

//--- dv/drive_control_word_decoder_tb_top.sv
// testbench for the drive control word decoder
`timescale 1ns/1ps
`default_nettype none
module drive_control_word_decoder_tb_top
	import dcwd_pkg::*;
;
	logic mclk_i, reset_i, wr_valid, wr_size32, chan_mb, chan_blk, ack, err, start;
	logic [15:0] wr_addr, ref16;
	logic [31:0] wr_data, ref32;
	logic [3:0] state, msel;
	logic [2:0] mact;
	logic [6:0] cmd;
	int fail_count, tests_run;

	dcwd_top DUT (.mclk_i(mclk_i), .reset_i(reset_i), .wr_valid_i(wr_valid),
		.wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_size32_i(wr_size32),
		.channel_modbus_i(chan_mb), .channel_blocked_i(chan_blk), .drive_state_i(state),
		.resp_ack_o(ack), .resp_err_o(err), .power_off_request_o(cmd[0]),
		.power_on_request_o(cmd[1]), .emergency_decel_request_o(cmd[2]),
		.error_clear_request_o(cmd[3]), .pause_request_o(cmd[4]),
		.pause_clear_request_o(cmd[5]), .pause_resume_request_o(cmd[6]),
		.mode_start_o(start), .mode_select_o(msel), .mode_action_o(mact),
		.ref16_o(ref16), .ref32_o(ref32));

	dcwd_ctrl_model u_ctrl (.mclk_i(mclk_i), .resp_ack_i(ack), .resp_err_i(err),
		.wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
		.wr_size32_o(wr_size32));

	// 25 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// counted comparison
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// one write with its answer and the pulses in the answer cycle
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic sz,
		input logic [1:0] er, input logic [7:0] ec);
		logic [1:0] r;
		u_ctrl.write(a, d, sz, r);
		chk("resp", {30'h0, er}, {30'h0, r});
		chk("pulses", {24'h0, ec}, {24'h0, start, cmd});
	endtask

	// power stage precedence, zero word, edges only
	task automatic s_power();
		state = DCWD_ST_READY;
		wr(DCWD_ADDR_CMD, 32'h0000_0300, 1'b1, 2'h1, 8'h01);
		wr(DCWD_ADDR_CMD, 32'h0000_0000, 1'b1, 2'h1, 8'h01);
		wr(DCWD_ADDR_CMD, 32'h0000_0200, 1'b1, 2'h1, 8'h02);
		wr(DCWD_ADDR_CMD, 32'h0000_0200, 1'b1, 2'h1, 8'h00);
	endtask

	// quick stop, fault reset and a request illegal in state
	task automatic s_state();
		state = DCWD_ST_RUNNING;
		wr(DCWD_ADDR_CMD, 32'h0000_0c00, 1'b1, 2'h1, 8'h04);
		wr(DCWD_ADDR_CMD, 32'h0000_0000, 1'b1, 2'h1, 8'h01);
		state = DCWD_ST_FAULT;
		wr(DCWD_ADDR_CMD, 32'h0000_0800, 1'b1, 2'h1, 8'h08);
		state = DCWD_ST_READY;
		wr(DCWD_ADDR_CMD, 32'h0000_0400, 1'b1, 2'h1, 8'h00);
		state = DCWD_ST_SWITCHED_ON;
		wr(DCWD_ADDR_CMD, 32'h0000_0000, 1'b1, 2'h1, 8'h01);
		wr(DCWD_ADDR_CMD, 32'h0000_0600, 1'b1, 2'h1, 8'h06);
	endtask

	// halt group precedence and following edges
	task automatic s_pause();
		state = DCWD_ST_RUNNING;
		wr(DCWD_ADDR_CMD, 32'h0000_e000, 1'b1, 2'h1, 8'h10);
		wr(DCWD_ADDR_CMD, 32'h0000_0000, 1'b1, 2'h1, 8'h01);
		wr(DCWD_ADDR_CMD, 32'h0000_4000, 1'b1, 2'h1, 8'h20);
		wr(DCWD_ADDR_CMD, 32'h0000_8000, 1'b1, 2'h1, 8'h40);
	endtask

	// refused accesses leave the held command untouched
	task automatic s_refuse();
		state = DCWD_ST_READY;
		for (int i = 0; i < 4; i++) begin
			chan_mb = (i != 2);
			chan_blk = (i == 3);
			wr((i == 1) ? 16'h1b0b : DCWD_ADDR_CMD, 32'h0000_0200, i != 0, 2'h2, 8'h00);
		end
		chan_mb = 1'b1;
		chan_blk = 1'b0;
		wr(DCWD_ADDR_CMD, 32'h0000_0200, 1'b1, 2'h1, 8'h02);
	endtask

	// mode data taken only on a toggle, zero mode byte skipped
	task automatic s_mode();
		wr(DCWD_ADDR_REF, 32'h1234_5678, 1'b1, 2'h1, 8'h00);
		wr(DCWD_ADDR_CMD, 32'h0005_0283, 1'b1, 2'h1, 8'h80);
		chk("ref32", 32'h1234_5678, ref32);
		chk("fields", 32'h0005_0003, {ref16, 9'h0, mact, msel});
		wr(DCWD_ADDR_REF, 32'h0bad_f00d, 1'b1, 2'h1, 8'h00);
		wr(DCWD_ADDR_CMD, 32'h0009_0200, 1'b1, 2'h1, 8'h00);
		chk("ref32", 32'h1234_5678, ref32);
		chk("fields", 32'h0005_0003, {ref16, 9'h0, mact, msel});
		wr(DCWD_ADDR_CMD, 32'h0009_0213, 1'b1, 2'h1, 8'h00);
		wr(DCWD_ADDR_CMD, 32'h0009_0293, 1'b1, 2'h1, 8'h80);
		chk("ref32", 32'h0bad_f00d, ref32);
		chk("fields", 32'h0009_0013, {ref16, 9'h0, mact, msel});
	endtask

	// every output back at its reset value
	task automatic chk_reset();
		chk("reset pulses", 32'h0, {22'h0, ack, err, start, cmd});
		chk("reset fields", 32'h0, {ref16, 9'h0, mact, msel});
		chk("reset ref32", 32'h0, ref32);
	endtask

	// reset in mid-run clears outputs and the held command
	task automatic s_reset();
		state = DCWD_ST_READY;
		@(posedge mclk_i);
		#1;
		reset_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		reset_i = 1'b0;
		chk_reset();
		wr(DCWD_ADDR_CMD, 32'h0000_0200, 1'b1, 2'h1, 8'h02);
	endtask

	// verdict and end of run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end

	// reset, then the scenarios
	initial begin
		fail_count = 0;
		tests_run = 0;
		reset_i = 1'b1;
		chan_mb = 1'b1;
		chan_blk = 1'b0;
		state = DCWD_ST_READY;
		repeat (10) @(posedge mclk_i);
		#1;
		reset_i = 1'b0;
		chk_reset();
		s_power();
		s_state();
		s_pause();
		s_refuse();
		s_mode();
		s_reset();
		stop_test();
	end
endmodule
`default_nettype wire
